// >>> hw/pbs_consts.svh
// Constants of the pipelined burst SRAM block: widths, depth, reset values.
// Included by the package and by every design file; definitions only.
`ifndef PBS_CONSTS_SVH
`define PBS_CONSTS_SVH

`define PBS_ADDR_W     17
`define PBS_DATA_W     32
`define PBS_UPPER_W    15
`define PBS_DEPTH      131072
`define PBS_CNT_W      2
`define PBS_SYNC_W     3
`define PBS_SYNC_RST   3'h0
`define PBS_WORD_RST   32'h0000_0000
`define PBS_UPPER_RST  15'h0000
`define PBS_CNT_RST    2'h0
`define PBS_SYNC_OE    0
`define PBS_SYNC_SLEEP 1
`define PBS_SYNC_MODE  2

`endif

// >>> hw/pbs_pkg.sv
// Types of the pipelined burst SRAM block.
// Assumes the constants header is on the include path.
`include "pbs_consts.svh"

package pbs_pkg;

  // Gray coded along deselected -> active, sleep one step further
  typedef enum logic [1:0] {
    PBS_DESEL  = 2'h0,
    PBS_ACTIVE = 2'h1,
    PBS_SLEEP  = 2'h3
  } pbs_state_t;

  typedef logic [`PBS_ADDR_W-1:0]  pbs_addr_t;
  typedef logic [`PBS_DATA_W-1:0]  pbs_word_t;
  typedef logic [`PBS_UPPER_W-1:0] pbs_upper_t;
  typedef logic [`PBS_CNT_W-1:0]   pbs_cnt_t;

endpackage

// >>> hw/pbs_burst_ctr.sv
// Two-bit wraparound burst counter, linear or interleaved order.
// Assumes load and step come from logic on the same clock.
`timescale 1ns/1ps
`include "pbs_consts.svh"

module pbs_burst_ctr
  import pbs_pkg::*;
(
  input  wire logic     clk_i,        // Core clock
  input  wire logic     arst_n_i,     // Asynchronous reset, active low
  input  wire logic     load_i,       // Load start offset, restart sequence
  input  wire logic     step_i,       // Advance to next burst location
  input  wire logic     interleave_i, // High: interleaved, low: linear
  input  wire pbs_cnt_t start_i,      // Low address bits at the strobe
  output pbs_cnt_t      cnt_o,        // Offset of the current location
  output pbs_cnt_t      next_o        // Offset of the following location
);

  pbs_cnt_t start_q;
  pbs_cnt_t start_d;
  pbs_cnt_t seq_q;
  pbs_cnt_t seq_d;
  pbs_cnt_t seq_inc;

  always_comb begin
    seq_inc = seq_q + 2'h1;
    cnt_o   = interleave_i ? (start_q ^ seq_q) : (start_q + seq_q);
    next_o  = interleave_i ? (start_q ^ seq_inc) : (start_q + seq_inc);
    start_d = start_q;
    seq_d   = seq_q;
    if (load_i) begin
      start_d = start_i;
      seq_d   = `PBS_CNT_RST;
    end else if (step_i) begin
      seq_d = seq_inc;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_q <= `PBS_CNT_RST;
      seq_q   <= `PBS_CNT_RST;
    end else begin
      start_q <= start_d;
      seq_q   <= seq_d;
    end
  end

endmodule

// >>> hw/pbs_sram_ctrl.sv
// Pipelined synchronous burst SRAM, 128K x 32, common data I/O.
// Assumes the bus controls are synchronous to REF_CLK_I; output enable,
// sleep and the burst-order strap are asynchronous and are synchronised.
// Pin pull-up and pull-down resistors live in the pad ring.
//
// Functional notes
// - Second enable high, third enable low select
// - First enable low; high disregards processor strobe
// - Output enable low drives data lines
// - Output enable high floats lines, accepts writes
// - First read clock from deselect stays floating
// - Advance low steps burst address
// - Processor strobe captures address, loads counter
// - Both strobes low: processor strobe wins
// - First enable high ignores processor strobe
// - Controller strobe captures address, loads counter
// - Sleep input high: idle, contents kept
// - Sleep held low normally; pad pull-down
// - Write data registered at rising edge
// - Read data one pipeline stage later
// - Deselect floats outputs after next edge
// - Write cycle forces data lines floating
// - Strap low linear, high interleaved order
`timescale 1ns/1ps
`include "pbs_consts.svh"

module pbs_sram_ctrl
  import pbs_pkg::*;
(
  input  wire logic      REF_CLK_I,             // 100 MHz clock
  input  wire logic      ARST_N_I,              // Asynchronous reset, active low
  input  wire pbs_addr_t ADDR_I,                // Word address
  input  wire logic      CHIP_SEL_PIPE_N_I,     // First chip enable, active low
  input  wire logic      CHIP_SEL_DEPTH_HI_I,   // Second chip enable, active high
  input  wire logic      CHIP_SEL_DEPTH_N_I,    // Third chip enable, active low
  input  wire logic      PROC_ADDR_STROBE_N_I,  // Processor address strobe
  input  wire logic      CTRL_ADDR_STROBE_N_I,  // Controller address strobe
  input  wire logic      BURST_STEP_N_I,        // Burst advance, active low
  input  wire logic      WRITE_N_I,             // Write request, active low
  input  wire logic      OUT_EN_N_I,            // Asynchronous output enable
  input  wire logic      SLEEP_REQ_I,           // Asynchronous sleep request
  input  wire logic      BURST_MODE_I,          // Strap: low linear, high interleaved
  input  wire pbs_word_t DQ_I,                  // Data lines, input side
  output pbs_word_t      DQ_O,                  // Data lines, output side
  output logic           DQ_OE_N_O              // Data line enable, low drives
);

  logic [`PBS_SYNC_W-1:0] meta_q;
  logic [`PBS_SYNC_W-1:0] sync_q;
  logic       oe_s;
  logic       sleep_s;
  logic       mode_s;
  logic       sel;
  logic       p_stb;
  logic       c_stb;
  logic       stb;
  logic       awake;
  logic       start_sel;
  logic       desel;
  logic       cont;
  logic       step;
  logic       wr;
  logic       rd;
  logic       fresh;
  pbs_addr_t  op_addr;
  pbs_cnt_t   cnt;
  pbs_cnt_t   nxt;
  pbs_state_t state_q;
  pbs_state_t state_d;
  pbs_upper_t upper_q;
  pbs_upper_t upper_d;
  logic       rd_pend_q;
  logic       rd_pend_d;
  pbs_word_t  mem_q;
  pbs_word_t  dq_q;
  pbs_word_t  dq_d;
  logic       oe_n_q;
  logic       oe_n_d;
  pbs_word_t  mem [0:`PBS_DEPTH-1];

  // Two-stage synchronisers; only sync_q is read by logic
  // sleep resets low, pad pull-down
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      meta_q <= `PBS_SYNC_RST;
      sync_q <= `PBS_SYNC_RST;
    end else begin
      meta_q <= {BURST_MODE_I, SLEEP_REQ_I, OUT_EN_N_I};
      sync_q <= meta_q;
    end
  end

  assign oe_s    = !sync_q[`PBS_SYNC_OE];
  assign sleep_s = sync_q[`PBS_SYNC_SLEEP];
  assign mode_s  = sync_q[`PBS_SYNC_MODE];

  always_comb begin
    sel     = !CHIP_SEL_PIPE_N_I && CHIP_SEL_DEPTH_HI_I && !CHIP_SEL_DEPTH_N_I;
    p_stb   = !PROC_ADDR_STROBE_N_I && !CHIP_SEL_PIPE_N_I;
    c_stb   = !CTRL_ADDR_STROBE_N_I && !p_stb;
    stb     = p_stb || c_stb;
    awake   = !sleep_s;
    start_sel = stb && sel && awake;
    desel   = stb && !sel && awake;
    cont    = !stb && awake && (state_q == PBS_ACTIVE);
    step    = cont && !BURST_STEP_N_I;
    op_addr = start_sel ? ADDR_I : {upper_q, (step ? nxt : cnt)};
    // Processor-strobe writes take effect one clock later, hence c_stb only
    wr      = awake && !WRITE_N_I && ((c_stb && start_sel) || cont);
    rd      = (start_sel && (p_stb || WRITE_N_I)) || (cont && WRITE_N_I);
    fresh   = start_sel && (state_q != PBS_ACTIVE);
  end

  pbs_burst_ctr u_burst (
    .clk_i        (REF_CLK_I),
    .arst_n_i     (ARST_N_I),
    .load_i       (start_sel),
    .step_i       (step),
    .interleave_i (mode_s),
    .start_i      (ADDR_I[`PBS_CNT_W-1:0]),
    .cnt_o        (cnt),
    .next_o       (nxt)
  );

  always_comb begin
    state_d   = state_q;
    upper_d   = upper_q;
    rd_pend_d = rd;
    dq_d      = mem_q;
    // A start on the wake-up edge must still open its burst
    if (sleep_s) begin
      state_d = PBS_SLEEP;
    end else if (start_sel) begin
      state_d = PBS_ACTIVE;
    end else if (desel || (state_q == PBS_SLEEP)) begin
      state_d = PBS_DESEL;
    end
    if (start_sel) begin
      upper_d = ADDR_I[`PBS_ADDR_W-1:`PBS_CNT_W];
    end
    oe_n_d = !(rd_pend_q && oe_s);
    if (!oe_s || wr || fresh || sleep_s) begin
      oe_n_d = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_q   <= PBS_DESEL;
      upper_q   <= `PBS_UPPER_RST;
      rd_pend_q <= 1'b0;
      dq_q      <= `PBS_WORD_RST;
      oe_n_q    <= 1'b1;
    end else begin
      state_q   <= state_d;
      upper_q   <= upper_d;
      rd_pend_q <= rd_pend_d;
      dq_q      <= dq_d;
      oe_n_q    <= oe_n_d;
    end
  end

  // Storage has no reset: contents survive reset and sleep alike
  always_ff @(posedge REF_CLK_I) begin
    if (wr) begin
      mem[op_addr] <= DQ_I;
    end
    if (rd) begin
      mem_q <= mem[op_addr];
    end
  end

  assign DQ_O      = dq_q;
  assign DQ_OE_N_O = oe_n_q;

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  sequence s_read_start;
    rd && oe_s && !fresh;
  endsequence

  sequence s_read_hold;
    oe_s && awake && !wr && !fresh;
  endsequence

  a_read_data_out: assert property (s_read_start ##1 s_read_hold |=>
      (!DQ_OE_N_O && DQ_O == $past(mem_q)))
    else $error("read word not driven one stage after access");

  a_write_float: assert property (wr |=> DQ_OE_N_O)
    else $error("data lines driven in a write cycle");

  a_oe_high_float: assert property (!oe_s |=> DQ_OE_N_O)
    else $error("data lines driven with output enable high");

  a_fresh_mask: assert property (fresh |=> DQ_OE_N_O)
    else $error("first read clock after deselect not floating");

  a_sleep_quiet: assert property (sleep_s |=> (DQ_OE_N_O && state_q == PBS_SLEEP))
    else $error("sleep did not idle the device");

  a_proc_ignored: assert property ((CHIP_SEL_PIPE_N_I && CTRL_ADDR_STROBE_N_I)
      |=> $stable(upper_q) && ($stable(state_q) || $past(sleep_s) ||
           $past(state_q) == PBS_SLEEP))
    else $error("processor strobe taken with first enable high");

  a_proc_wins_load: assert property ((p_stb && !CTRL_ADDR_STROBE_N_I && sel && awake)
      |=> (upper_q == $past(ADDR_I[`PBS_ADDR_W-1:`PBS_CNT_W]) &&
           cnt == $past(ADDR_I[`PBS_CNT_W-1:0])))
    else $error("processor strobe address not captured");

  a_ctrl_load: assert property ((c_stb && sel && awake)
      |=> (cnt == $past(ADDR_I[`PBS_CNT_W-1:0]) && state_q == PBS_ACTIVE))
    else $error("controller strobe address not captured");

  a_burst_step: assert property (step |=> cnt == $past(nxt))
    else $error("burst counter did not advance");

  a_upper_hold: assert property (cont [*2] |=> $stable(upper_q))
    else $error("upper address moved during burst");

  a_chip_desel: assert property ((stb && awake && !CHIP_SEL_DEPTH_HI_I)
      |=> state_q == PBS_DESEL)
    else $error("device selected with second enable low");

  a_desel_late: assert property ((desel && rd_pend_q && oe_s)
      |=> !DQ_OE_N_O ##1 DQ_OE_N_O)
    else $error("outputs did not float one edge after deselect");

  a_write_store: assert property (wr |=> mem[$past(op_addr)] == $past(DQ_I))
    else $error("write data not stored");

endmodule

// >>> verif/pbs_bus_host.sv
// Bus master model: selects, strobes, address and write data for the SRAM.
// Assumes one caller of op(); every command changes just after a falling edge.
`timescale 1ns/1ps

module pbs_bus_host
  import pbs_pkg::*;
(
  input  wire pbs_word_t dev_dq_i,   // Device data, output side
  input  wire logic      dev_oe_n_i, // Device drive enable, low drives
  input  wire logic      clk_i,      // Bus clock
  output pbs_addr_t      addr_o,     // Word address
  output logic [6:0]     ctl_o,      // pipe_n,depth_hi,depth_n,proc_n,ctrl_n,step_n,write_n
  output pbs_word_t      dq_o        // Resolved data line level
);
  // Idle, ctrl read, ctrl write, proc read, step, deselect, both strobes, proc unqualified,
  // deselect by third enable, continuation write
  localparam logic [6:0] TBL [10] = '{7'h6f, 7'h2b, 7'h2a, 7'h27, 7'h6d, 7'h0b, 7'h22, 7'h67,
                                      7'h3b, 7'h6e};
  logic      drv;
  pbs_word_t wd;
  pbs_word_t last_q;

  // A released line shows a changing pattern so stale data never passes
  assign dq_o = drv ? wd : (!dev_oe_n_i ? dev_dq_i : ~last_q);

  always @(posedge clk_i) begin
    last_q <= dq_o;
  end

  initial begin
    ctl_o = TBL[0];
    addr_o = '0;
    drv = 1'b0;
    wd = '0;
    last_q = '0;
  end

  task automatic op(input int k, input pbs_addr_t a, input pbs_word_t d);
    @(negedge clk_i);
    ctl_o = TBL[k];
    addr_o = a;
    wd = d;
    drv = (k == 2) || (k == 9);
  endtask
endmodule

// >>> verif/pbs_sram_ctrl_tb.sv
// Self-checking bench of the burst SRAM block with a bus master model.
// Assumes outputs seen after one op() reflect the edge of the op before it.
`timescale 1ns/1ps

module pbs_sram_ctrl_tb;
  import pbs_pkg::*;
  localparam pbs_addr_t A0 = 17'h0_3c21;
  localparam pbs_addr_t B0 = 17'h1_5a54;
  localparam pbs_word_t D0 = 32'h1357_9bdf;
  localparam pbs_word_t D1 = 32'h8642_fdb9;
  logic      clk = 1'b0;
  logic      rst_n = 1'b0;
  logic      oe_n = 1'b0;
  // Sleep held low for normal operation
  logic      sleep = 1'b0;
  logic      mode = 1'b0;
  pbs_addr_t addr;
  logic [6:0] ctl;
  pbs_word_t dq_i;
  pbs_word_t dq_o;
  logic      dq_oe_n;
  int        error_cnt = 0;
  int        compares = 0;
  int        cyc = 0;

  always #5 clk = ~clk;

  pbs_bus_host host_u (.dev_dq_i(dq_o), .dev_oe_n_i(dq_oe_n), .clk_i(clk),
                       .addr_o(addr), .ctl_o(ctl), .dq_o(dq_i));

  pbs_sram_ctrl dut_u (.REF_CLK_I(clk), .ARST_N_I(rst_n), .ADDR_I(addr),
    .CHIP_SEL_PIPE_N_I(ctl[6]), .CHIP_SEL_DEPTH_HI_I(ctl[5]), .CHIP_SEL_DEPTH_N_I(ctl[4]),
    .PROC_ADDR_STROBE_N_I(ctl[3]), .CTRL_ADDR_STROBE_N_I(ctl[2]), .BURST_STEP_N_I(ctl[1]),
    .WRITE_N_I(ctl[0]), .OUT_EN_N_I(oe_n), .SLEEP_REQ_I(sleep), .BURST_MODE_I(mode),
    .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE_N_O(dq_oe_n));

  function automatic pbs_word_t pat(input int i);
    return 32'ha5c3_0000 + 32'(i);
  endfunction

  task automatic results;
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_w(input pbs_word_t got, input pbs_word_t exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic op(input int k, input pbs_addr_t a = '0, input pbs_word_t d = '0);
    host_u.op(k, a, d);
  endtask

  task automatic nop(input int n);
    repeat (n) op(0);
  endtask

  task automatic t_write_read;
    op(2, A0, D0);
    for (int i = 0; i < 4; i++) op(2, B0 | 17'(i), pat(i));
    op(1, A0);
    nop(2);
    chk_w(dq_o, D0);
    chk_b(dq_oe_n, 1'b0);
  endtask

  task automatic t_burst(input logic m, input int s);
    mode = m;
    nop(3);
    op(3, B0 | 17'(s));
    for (int j = 0; j < 5; j++) begin
      op(j < 3 ? 4 : 0);
      if (j > 0) begin
        chk_w(dq_o, pat(m ? (s ^ (j - 1)) : ((s + j - 1) & 3)));
      end
    end
  endtask

  task automatic t_oe_write;
    oe_n = 1'b1;
    nop(3);
    chk_b(dq_oe_n, 1'b1);
    oe_n = 1'b0;
    nop(3);
    chk_b(dq_oe_n, 1'b0);
    op(2, A0 ^ 17'h1, 32'h2468_ace0);
    op(0);
    chk_b(dq_oe_n, 1'b1);
    op(1, A0 ^ 17'h1);
    nop(2);
    chk_w(dq_o, 32'h2468_ace0);
  endtask

  // Processor-strobe write: data lands on the second edge
  task automatic t_proc_write;
    op(3, A0 ^ 17'h2);
    op(9, A0 ^ 17'h2, D1);
    op(0);
    chk_b(dq_oe_n, 1'b1);
    op(1, A0 ^ 17'h2);
    nop(2);
    chk_w(dq_o, D1);
    chk_b(dq_oe_n, 1'b0);
  endtask

  task automatic t_deselect(input int k);
    op(1, A0);
    op(0);
    op(k, A0);
    op(0);
    chk_b(dq_oe_n, 1'b0);
    chk_w(dq_o, D0);
    op(0);
    chk_b(dq_oe_n, 1'b1);
  endtask

  // An ignored strobe mid-burst must leave the burst running
  task automatic t_proc_ignored;
    op(1, A0);
    op(0);
    op(7, A0);
    nop(2);
    chk_b(dq_oe_n, 1'b0);
    chk_w(dq_o, D0);
    op(5, A0);
    nop(2);
    chk_b(dq_oe_n, 1'b1);
  endtask

  task automatic t_both;
    op(6, A0, 32'hffff_0000);
    op(0);
    chk_b(dq_oe_n, 1'b1);
    op(0);
    chk_b(dq_oe_n, 1'b0);
    chk_w(dq_o, D0);
  endtask

  task automatic t_sleep;
    sleep = 1'b1;
    nop(3);
    op(1, A0);
    nop(2);
    chk_b(dq_oe_n, 1'b1);
    sleep = 1'b0;
    nop(3);
    op(1, A0);
    nop(2);
    chk_w(dq_o, D0);
    chk_b(dq_oe_n, 1'b0);
  endtask

  // Whole sequence needs under a hundred cycles; ceiling leaves ample margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_write_read();
    t_burst(1'b0, 1);
    t_burst(1'b1, 1);
    t_oe_write();
    t_proc_write();
    t_deselect(5);
    t_deselect(8);
    t_proc_ignored();
    t_both();
    t_sleep();
    results();
  end
endmodule
